// [logic/ccs_regs.vh]
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
// State codes of the charge sequencer
`define CCS_ST_IDLE     3'h0
`define CCS_ST_TRICKLE  3'h1
`define CCS_ST_CC       3'h2
`define CCS_ST_CV       3'h3
`define CCS_ST_DONE     3'h4
`define CCS_ST_FAULT    3'h5
`define CCS_ST_INHIBIT  3'h6
// Status encodings {a,b}
`define CCS_STAT_CHG    2'h0
`define CCS_STAT_DONE   2'h1
`define CCS_STAT_FAULT  2'h2
`define CCS_STAT_SUSP   2'h3
// Regulator modes
`define CCS_MODE_OFF    2'h0
`define CCS_MODE_LINEAR 2'h1
`define CCS_MODE_SWITCH 2'h2
// Safety timer exponents, in oscillator periods
`define CCS_TIMEOUT_EXP  22
`define CCS_TRICKLE_EXP  19
`define CCS_TIMER_W      23
`define CCS_TMO_FULL     23'h40_0000
`define CCS_TMO_TRK      23'h08_0000
// Deglitch interval of battery presence
`define CCS_DEGLITCH_MS  12
`define CCS_CLK_HZ       20000000
`define CCS_DEGLITCH_CYC 18'h3_a980 // 12 ms of 50 ns clocks
`define CCS_DEG_W        18
`endif

// [logic/ccs_charge_sequencer.v]
// Notes on behaviour
// - Power-on reset clears timer and starts a charge cycle.
// - Below low precharge level, run linear mode at fixed current.
// - At high precharge level, leave linear mode and switch.
// - Cycle starts in trickle; moves to constant current above both high precharge level and minimum voltage.
// - At final voltage, move from constant current to constant voltage.
// - In constant voltage, taper current ends charge and shows complete.
// - New cycle on reset, battery insertion, over-temperature recovery, enable falling.
// - After timeout, fault; the inhibit state is decoded but no transition ever enters it.
// - Trickle to constant current only if threshold reached before trickle timeout.
// - Taper before timeout gives charge complete and stops charging.
// - From complete, droop below recharge threshold restarts with timer cleared.
// - Timeout before taper gives fault and stops charging.
// - Output over-voltage gives fault whenever enable is low.
// - Fault holds until power cycle or enable toggled high then low.
// - Status: 00 charging, 01 complete, 10 fault, 11 suspend.
// - Trickle limit is one eighth of full timeout: 2^19 versus 2^22.
// - Battery presence deglitched over 12 ms before use.
// - Temperature outside window suspends charging; back inside window starts a new cycle.
`timescale 1ns/10ps
`default_nettype none
`include "ccs_regs.vh"
module ccs_charge_sequencer (
	// Clock and reset
	input  wire       ref_clk,
	input  wire       rstn,
	// Oscillator tick and enable pin
	input  wire       osc_tick,
	input  wire       enable_n,
	// Comparator results
	input  wire       below_precharge_low,
	input  wire       above_precharge_high,
	input  wire       above_min_fast,
	input  wire       at_final_voltage,
	input  wire       below_taper,
	input  wire       below_recharge,
	input  wire       over_voltage,
	input  wire       temp_in_window,
	input  wire       battery_present_raw,
	// Charger controls
	output reg  [1:0] reg_mode,
	output reg        cv_regulate,
	// Status outputs
	output reg        status_out_a,
	output reg        status_out_b
);
	localparam [`CCS_DEG_W-1:0]   DEG_CYC  = `CCS_DEGLITCH_CYC;
	localparam [`CCS_TIMER_W-1:0] TMO_FULL = `CCS_TMO_FULL;
	localparam [`CCS_TIMER_W-1:0] TMO_TRK  = `CCS_TMO_TRK;

	// Two-stage synchronisers for all asynchronous pins
	reg [10:0] s1_q;
	reg [10:0] s2_q;
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			// Idle pin levels: enable off, temperature good, battery present,
			// so the edge detectors see no false edge right after reset
			s1_q <= 11'h203;
			s2_q <= 11'h203;
		end else begin
			s1_q <= {osc_tick, enable_n, below_precharge_low, above_precharge_high,
				above_min_fast, at_final_voltage, below_taper, below_recharge,
				over_voltage, temp_in_window, battery_present_raw};
			s2_q <= s1_q;
		end
	end
	wire tick_s   = s2_q[10];
	wire en_n_s   = s2_q[9];
	wire pl_s     = s2_q[8];
	wire ph_s     = s2_q[7];
	wire vmin_s   = s2_q[6];
	wire vfin_s   = s2_q[5];
	wire taper_s  = s2_q[4];
	wire rech_s   = s2_q[3];
	wire ovp_s    = s2_q[2];
	wire temp_s   = s2_q[1];
	wire batraw_s = s2_q[0];

	// Edge memory for tick, enable, presence and temperature
	reg tick_prev_q;
	reg en_prev_q;
	reg bat_prev_q;
	reg temp_prev_q;
	// Deglitched presence; reset as present so power-up is not seen as insertion
	reg                 bat_q;
	reg [`CCS_DEG_W-1:0] deg_cnt_q;
	reg [2:0]            state_q;
	reg [2:0]            state_d;
	reg [`CCS_TIMER_W-1:0] timer_q;
	reg                  timer_clr;
	reg                  started_q;

	wire tick_rise = tick_s & ~tick_prev_q;
	wire en_fall   = en_prev_q & ~en_n_s;
	wire bat_ins   = bat_q & ~bat_prev_q;
	wire temp_rec  = temp_s & ~temp_prev_q;
	wire restart   = ~started_q | bat_ins | temp_rec | en_fall;

	// presence deglitch: must hold for the full interval
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			deg_cnt_q <= {`CCS_DEG_W{1'b0}};
			bat_q     <= 1'b1;
		end else if (batraw_s == bat_q) begin
			deg_cnt_q <= {`CCS_DEG_W{1'b0}};
		end else if (deg_cnt_q == DEG_CYC - 1'b1) begin
			deg_cnt_q <= {`CCS_DEG_W{1'b0}};
			bat_q     <= batraw_s;
		end else begin
			deg_cnt_q <= deg_cnt_q + 1'b1;
		end
	end

	// Edge history registers
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			tick_prev_q <= 1'b0;
			en_prev_q   <= 1'b1;
			bat_prev_q  <= 1'b1;
			temp_prev_q <= 1'b1;
			started_q   <= 1'b0;
		end else begin
			tick_prev_q <= tick_s;
			en_prev_q   <= en_n_s;
			bat_prev_q  <= bat_q;
			temp_prev_q <= temp_s;
			// first cycle after power-on sees enable off, so restart by started_q is overridden and en_fall starts charging
			started_q   <= 1'b1;
		end
	end

	wire charging = (state_q == `CCS_ST_TRICKLE) | (state_q == `CCS_ST_CC) |
		(state_q == `CCS_ST_CV);
	wire suspend  = ~temp_s | ~bat_q;

	// Sequencer next state
	always @* begin
		state_d   = state_q;
		timer_clr = 1'b0;
		if (en_n_s) begin
			state_d   = `CCS_ST_IDLE;
			timer_clr = 1'b1;
		end else if (ovp_s) begin
			state_d = `CCS_ST_FAULT;
		end else if (restart && state_q != `CCS_ST_FAULT) begin
			state_d   = `CCS_ST_TRICKLE;
			timer_clr = 1'b1;
		end else if (en_fall) begin
			state_d   = `CCS_ST_TRICKLE;
			timer_clr = 1'b1;
		end else if (!suspend) begin
			case (state_q)
				`CCS_ST_TRICKLE: begin
					if (timer_q >= TMO_TRK)
						state_d = `CCS_ST_FAULT;
					else if (ph_s && vmin_s)
						state_d = `CCS_ST_CC;
				end
				`CCS_ST_CC: begin
					if (timer_q >= TMO_FULL)
						state_d = `CCS_ST_FAULT;
					else if (vfin_s)
						state_d = `CCS_ST_CV;
				end
				`CCS_ST_CV: begin
					if (taper_s)
						state_d = `CCS_ST_DONE;
					else if (timer_q >= TMO_FULL)
						state_d = `CCS_ST_FAULT;
				end
				`CCS_ST_DONE, `CCS_ST_INHIBIT: begin
					if (rech_s) begin
						state_d   = `CCS_ST_TRICKLE;
						timer_clr = 1'b1;
					end
				end
				`CCS_ST_FAULT: state_d = `CCS_ST_FAULT;
				`CCS_ST_IDLE:  state_d = `CCS_ST_IDLE;
				default:       state_d = `CCS_ST_IDLE;
			endcase
		end
	end

	// State and safety timer
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= `CCS_ST_IDLE;
			timer_q <= {`CCS_TIMER_W{1'b0}};
		end else begin
			state_q <= state_d;
			// timer runs only while charging and not suspended
			if (timer_clr)
				timer_q <= {`CCS_TIMER_W{1'b0}};
			else if (charging && !suspend && tick_rise && timer_q != TMO_FULL)
				timer_q <= timer_q + 1'b1;
		end
	end

	// Registered outputs
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			reg_mode     <= `CCS_MODE_OFF;
			cv_regulate  <= 1'b0;
			status_out_a <= 1'b1;
			status_out_b <= 1'b1;
		end else begin
			// linear in trickle below low level, off when not charging or suspended, switching otherwise
			if (!charging || suspend)
				reg_mode <= `CCS_MODE_OFF;
			else if (state_q == `CCS_ST_TRICKLE && pl_s && !ph_s)
				reg_mode <= `CCS_MODE_LINEAR;
			else
				reg_mode <= `CCS_MODE_SWITCH;
			cv_regulate <= (state_q == `CCS_ST_CV) & ~suspend;
			if (state_q == `CCS_ST_FAULT)
				{status_out_a, status_out_b} <= `CCS_STAT_FAULT;
			else if (state_q == `CCS_ST_DONE || state_q == `CCS_ST_INHIBIT)
				{status_out_a, status_out_b} <= `CCS_STAT_DONE;
			else if (charging && !suspend)
				{status_out_a, status_out_b} <= `CCS_STAT_CHG;
			else
				{status_out_a, status_out_b} <= `CCS_STAT_SUSP;
		end
	end
endmodule
`default_nettype wire

// [tb/ccs_checker_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_checker (
	// Clock and reset
	input wire logic       ref_clk,
	input wire logic       rstn,
	// Steering inputs
	input wire logic       enable_n,
	input wire logic       over_voltage,
	input wire logic       temp_in_window,
	// Watched outputs
	input wire logic [1:0] reg_mode,
	input wire logic       cv_regulate,
	input wire logic       status_out_a,
	input wire logic       status_out_b
);
	// Status pair as one code
	wire [1:0] st;
	assign st = {status_out_a, status_out_b};
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// Six samples cover the input sync plus state and output stages
	chk_idle_when_off: assert property (enable_n [*6] |-> st == 2'h3 && reg_mode == 2'h0)
		else $error("not idle with enable off");
	chk_ovp_to_fault: assert property ((over_voltage && temp_in_window && !enable_n) [*6] |-> st == 2'h2)
		else $error("over-voltage did not fault");
	chk_fault_holds: assert property ((!enable_n) [*6] ##0 st == 2'h2 |=> st == 2'h2)
		else $error("fault left without enable toggle");
	chk_fault_stops: assert property (st == 2'h2 |-> reg_mode == 2'h0 && !cv_regulate)
		else $error("charging during fault");
	chk_done_stops: assert property (st == 2'h1 |-> reg_mode == 2'h0 && !cv_regulate)
		else $error("charging after complete");
	chk_suspend_stops: assert property (st == 2'h3 |-> reg_mode == 2'h0 && !cv_regulate)
		else $error("charging while suspended");
	chk_cv_switching: assert property (cv_regulate |-> reg_mode == 2'h2 && st == 2'h0)
		else $error("voltage mode without switching");
	chk_linear_trickle: assert property (reg_mode == 2'h1 |-> !cv_regulate && st == 2'h0)
		else $error("linear mode outside trickle");
	chk_mode_legal: assert property (reg_mode != 2'h3)
		else $error("illegal regulator mode");
	cover property (st == 2'h1);
	cover property (st == 2'h2);
	cover property (cv_regulate);
	cover property (reg_mode == 2'h1);
endmodule
bind ccs_charge_sequencer ccs_checker chk (.ref_clk, .rstn, .enable_n, .over_voltage,
	.temp_in_window, .reg_mode, .cv_regulate, .status_out_a, .status_out_b);
`default_nettype wire

// [tb/ccs_status_host.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_status_host (
	// Clock
	input wire logic       ref_clk,
	// Status pins
	input wire logic       status_out_a,
	input wire logic       status_out_b,
	// Decoded condition
	output var logic [1:0] cond
);
	// status pin decode
	// Polled once a clock, so a one-cycle glitch is not filtered
	always @(posedge ref_clk) begin
		cond <= {status_out_a, status_out_b};
	end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        ref_clk = 0;
	logic        rstn = 0;
	logic        osc_tick = 0;
	logic        enable_n = 0;
	logic [8:0]  v = 9'h181;
	logic [2:0]  div = 0;
	logic [1:0]  reg_mode, cond;
	logic        cv_regulate, status_out_a, status_out_b;
	logic [31:0] r = 32'h038b;
	int          n_mismatch = 0;
	int          total_checks = 0;
	// Clock, 50 ns period
	always #25 ref_clk = ~ref_clk;
	// Tick every eight clocks, slow enough for the sync stage
	always @(posedge ref_clk) begin
		div <= div + 3'h1;
		osc_tick <= div[2];
	end
	ccs_charge_sequencer dut (.ref_clk, .rstn, .osc_tick, .enable_n,
		.below_precharge_low(v[0]), .above_precharge_high(v[1]), .above_min_fast(v[2]),
		.at_final_voltage(v[3]), .below_taper(v[4]), .below_recharge(v[5]),
		.over_voltage(v[6]), .temp_in_window(v[7]), .battery_present_raw(v[8]),
		.reg_mode, .cv_regulate, .status_out_a, .status_out_b);
	ccs_status_host host (.ref_clk, .status_out_a, .status_out_b, .cond);
	function automatic [31:0] lfsr(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Linear only below the low level and not above the high one
	function automatic [1:0] fmode(input [8:0] x, input [1:0] es);
		return (es != 2'h0) ? 2'h0 : ((x[0] && !x[1]) ? 2'h1 : 2'h2);
	endfunction
	task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Eight clocks leave room for sync, state and host polling
	task automatic step(input logic [8:0] nv, input logic [1:0] es, input logic ecv);
		v = nv;
		repeat (8) @(posedge ref_clk);
		#5;
		chk("status", {2'h0, cond}, {2'h0, es});
		chk("mode", {2'h0, reg_mode}, {2'h0, fmode(nv, es)});
		chk("cv", {3'h0, cv_regulate}, {3'h0, ecv});
	endtask
	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred clocks the run needs
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		report_and_stop;
	end
	// Main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		#5;
		rstn = 1;
		step(9'h181, 2'h0, 1'h0);
		step(9'h180, 2'h0, 1'h0);
		step(9'h18a, 2'h0, 1'h0);
		step(9'h18e, 2'h0, 1'h1);
		step(9'h19e, 2'h1, 1'h0);
		for (int i = 0; i < 16; i++) begin
			r = lfsr(r);
			step({4'hc, r[4:0]}, 2'h1, 1'h0);
		end
		step(9'h1a0, 2'h0, 1'h0);
		step(9'h100, 2'h3, 1'h0);
		step(9'h180, 2'h0, 1'h0);
		step(9'h1c0, 2'h2, 1'h0);
		step(9'h180, 2'h2, 1'h0);
		// Power cycle in mid-run leaves fault and starts a new cycle
		rstn = 0;
		repeat (2) @(posedge ref_clk);
		#5;
		rstn = 1;
		step(9'h180, 2'h0, 1'h0);
		step(9'h1c0, 2'h2, 1'h0);
		step(9'h180, 2'h2, 1'h0);
		enable_n = 1;
		step(9'h180, 2'h3, 1'h0);
		enable_n = 0;
		step(9'h181, 2'h0, 1'h0);
		report_and_stop;
	end
endmodule
`default_nettype wire
